// ### alu_status_multiplier_core.sv
// arithmetic core: two-stage fetch/execute, 8-bit unit, status flags, 8x8 multiplier
// the decoder supplies the operation for the word in execute; data memory
// answers the source read combinationally in the same cycle
`timescale 1ns/1ps
`default_nettype none
`include "alu_core_map.svh"
module alu_status_multiplier_core
  import alu_core_pkg::*;
(
  input  wire logic        clock_i,
  input  wire logic        rst_n_i,
  input  wire logic [15:0] insn_i,
  input  wire decode_t     dec_i,
  input  wire logic [7:0]  file_rdata_i,
  input  wire logic [7:0]  sfr_addr_i,
  input  wire logic        sfr_we_i,
  input  wire logic [7:0]  sfr_wdata_i,
  input  wire logic        sfr_re_i,
  output logic      [15:0] pc_o,
  output logic      [15:0] exec_insn_o,
  output logic      [7:0]  file_raddr_o,
  output dbus_t            dbus_o,
  output logic      [7:0]  accumulator_o,
  output logic      [7:0]  arith_status_reg_o,
  output logic      [15:0] product_o,
  output logic      [7:0]  sfr_rdata_o,
  output logic             stall_o
);
  logic [15:0] pc_r;
  logic [15:0] insn_r;
  logic [7:0]  accumulator_reg;
  logic [3:0]  arith_status_reg;
  logic [15:0] prod_r;
  logic [7:0]  sfr_rdata_r;
  dbus_t       dbus_r;
  pipe_state_t pstate_r;
  logic [7:0]  a_op;
  logic [7:0]  b_op;
  logic [8:0]  sum;
  logic [4:0]  low_sum;
  logic [7:0]  res;
  logic        c_nxt;
  logic        dc_nxt;
  logic        ov_nxt;
  logic        arith;
  logic        logic_op;
  logic        shift_op;
  logic        cin;
  logic        sub;
  logic        exec_ok;

  ////////////////////////////////////////////////////////////////////////////
  // accumulator and file operand
  assign a_op     = accumulator_reg;
  assign b_op     = file_rdata_i;
  assign exec_ok  = (pstate_r == ST_RUN);
  assign sub      = (dec_i.op == OP_SUB) || (dec_i.op == OP_SUBB);
  assign arith    = (dec_i.op == OP_ADD) || (dec_i.op == OP_ADDC) || sub;
  assign logic_op = (dec_i.op == OP_AND) || (dec_i.op == OP_IOR) || (dec_i.op == OP_XOR);
  assign shift_op = (dec_i.op == OP_RLC) || (dec_i.op == OP_RRC);
  // borrow convention: carry set means no borrow, so subtract-with-borrow adds carry
  assign cin      = (dec_i.op == OP_ADDC || dec_i.op == OP_SUBB) ? arith_status_reg[`F_CARRY]
                                                                 : sub;

  ////////////////////////////////////////////////////////////////////////////
  // two's complement add path
  always_comb begin
    logic [7:0] bx;
    bx      = sub ? ~a_op : a_op;
    sum     = {1'b0, b_op} + {1'b0, bx} + {8'h00, cin};
    low_sum = {1'b0, b_op[3:0]} + {1'b0, bx[3:0]} + {4'h0, cin};
    res     = sum[7:0];
    c_nxt   = sum[8];
    dc_nxt  = low_sum[4];
    ov_nxt  = (b_op[7] == bx[7]) && (sum[7] != b_op[7]);
    unique case (dec_i.op)
      OP_AND:  res = a_op & b_op;
      OP_IOR:  res = a_op | b_op;
      OP_XOR:  res = a_op ^ b_op;
      OP_RLC: begin
        res   = {b_op[6:0], arith_status_reg[`F_CARRY]};
        c_nxt = b_op[7];
      end
      OP_RRC: begin
        res   = {arith_status_reg[`F_CARRY], b_op[7:1]};
        c_nxt = b_op[0];
      end
      OP_MOVWF: res = a_op;
      OP_MOVFF: res = b_op;
      default: ;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // fetch stage, one flush cycle after two-cycle ops
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pc_r     <= `RST_PC;
      insn_r   <= `RST_INSN;
      pstate_r <= ST_RUN;
    end else if (sfr_we_i && sfr_addr_i == `A_PCL_ADDR) begin
      pc_r[7:0] <= sfr_wdata_i;
      pstate_r  <= ST_FLUSH;
    end else if (sfr_we_i && sfr_addr_i == `A_PCH_ADDR) begin
      pc_r[15:8] <= sfr_wdata_i;
      pstate_r   <= ST_FLUSH;
    end else if (exec_ok && (dec_i.op == OP_BRANCH || dec_i.op == OP_TABLE)) begin
      pstate_r <= ST_FLUSH;
      if (dec_i.op == OP_BRANCH)
        pc_r <= {dec_i.dst, dec_i.src};
      insn_r <= `RST_INSN;
    end else begin
      pstate_r <= ST_RUN;
      pc_r     <= pc_r + 16'h0001;
      insn_r   <= insn_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // flag update per op; sfr write loses to a same-cycle arithmetic, logic or shift op
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      arith_status_reg <= 4'h0;
    end else if (exec_ok && arith) begin
      arith_status_reg <= {ov_nxt, (res == 8'h00), dc_nxt, c_nxt};
    end else if (exec_ok && logic_op) begin
      arith_status_reg[`F_ZERO] <= (res == 8'h00);
    end else if (exec_ok && shift_op) begin
      arith_status_reg[`F_CARRY] <= c_nxt;
    end else if (sfr_we_i && sfr_addr_i == `A_STATUS_ADDR) begin
      arith_status_reg <= sfr_wdata_i[3:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // accumulator also written through the data map
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      accumulator_reg <= `RST_BYTE;
    end else if (exec_ok && dec_i.to_acc && (arith || logic_op || shift_op)) begin
      accumulator_reg <= res;
    end else if (sfr_we_i && sfr_addr_i == `A_ACC_ADDR) begin
      accumulator_reg <= sfr_wdata_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // single-cycle product
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i)
      prod_r <= {`RST_BYTE, `RST_BYTE};
    else if (exec_ok && dec_i.op == OP_MUL)
      prod_r <= {8'h00, a_op} * {8'h00, b_op};
  end

  ////////////////////////////////////////////////////////////////////////////
  // file results, including file-to-file moves
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      dbus_r <= '0;
    end else begin
      dbus_r.addr  <= dec_i.dst;
      dbus_r.wdata <= res;
      dbus_r.we    <= exec_ok && !dec_i.to_acc &&
                      (arith || logic_op || shift_op || dec_i.op == OP_MOVWF || dec_i.op == OP_MOVFF);
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i)
      sfr_rdata_r <= `RST_BYTE;
    else if (sfr_re_i)
      unique case (sfr_addr_i)
        `A_PCL_ADDR:    sfr_rdata_r <= pc_r[7:0];
        `A_PCH_ADDR:    sfr_rdata_r <= pc_r[15:8];
        `A_STATUS_ADDR: sfr_rdata_r <= {4'h0, arith_status_reg};
        `A_ACC_ADDR:    sfr_rdata_r <= accumulator_reg;
        `A_PRODL_ADDR:  sfr_rdata_r <= prod_r[7:0];
        `A_PRODH_ADDR:  sfr_rdata_r <= prod_r[15:8];
        default:        sfr_rdata_r <= `RST_BYTE;
      endcase
  end

  assign pc_o               = pc_r;
  assign exec_insn_o        = insn_r;
  assign file_raddr_o       = dec_i.src;
  assign dbus_o             = dbus_r;
  assign accumulator_o      = accumulator_reg;
  assign arith_status_reg_o = {4'h0, arith_status_reg};
  assign product_o          = prod_r;
  assign sfr_rdata_o        = sfr_rdata_r;
  assign stall_o            = (pstate_r == ST_FLUSH);

  ////////////////////////////////////////////////////////////////////////////
  property p_zero;
    @(posedge clock_i) disable iff (!rst_n_i)
      (exec_ok && arith) |=> arith_status_reg[`F_ZERO] == ($past(res) == 8'h00);
  endproperty
  a_zero: assert property (p_zero) else $error("zero flag wrong");
  property p_carry;
    @(posedge clock_i) disable iff (!rst_n_i)
      (exec_ok && arith && !sub && dec_i.op == OP_ADD) |=>
        arith_status_reg[`F_CARRY] == ($past({1'b0, b_op}) + $past({1'b0, a_op}) > 9'h0ff);
  endproperty
  a_carry: assert property (p_carry) else $error("carry wrong");
  property p_borrow;
    @(posedge clock_i) disable iff (!rst_n_i)
      (exec_ok && dec_i.op == OP_SUB) |=> arith_status_reg[`F_CARRY] == ($past(b_op) >= $past(a_op));
  endproperty
  a_borrow: assert property (p_borrow) else $error("borrow wrong");
  property p_half;
    @(posedge clock_i) disable iff (!rst_n_i)
      (exec_ok && dec_i.op == OP_ADD) |=>
        arith_status_reg[`F_HALF] == ({1'b0, $past(a_op[3:0])} + {1'b0, $past(b_op[3:0])} > 5'h0f);
  endproperty
  a_half: assert property (p_half) else $error("half carry wrong");
  property p_ovf;
    @(posedge clock_i) disable iff (!rst_n_i)
      (exec_ok && dec_i.op == OP_ADD) |=> arith_status_reg[`F_OVF] ==
        ($signed({$past(a_op[7]), $past(a_op)}) + $signed({$past(b_op[7]), $past(b_op)}) > 127 ||
         $signed({$past(a_op[7]), $past(a_op)}) + $signed({$past(b_op[7]), $past(b_op)}) < -128);
  endproperty
  a_ovf: assert property (p_ovf) else $error("overflow wrong");
  property p_mul;
    @(posedge clock_i) disable iff (!rst_n_i)
      (exec_ok && dec_i.op == OP_MUL) |=> prod_r == $past(a_op) * $past(b_op);
  endproperty
  a_mul: assert property (p_mul) else $error("product wrong");
  property p_flush;
    @(posedge clock_i) disable iff (!rst_n_i)
      (exec_ok && dec_i.op == OP_BRANCH && !sfr_we_i) |=> stall_o ##1 !stall_o || sfr_we_i;
  endproperty
  a_flush: assert property (p_flush) else $error("branch not two cycles");
  property p_fetch;
    @(posedge clock_i) disable iff (!rst_n_i)
      (exec_ok && !sfr_we_i && dec_i.op != OP_BRANCH && dec_i.op != OP_TABLE) |=>
        insn_r == $past(insn_i) && pc_r == $past(pc_r) + 16'h0001;
  endproperty
  a_fetch: assert property (p_fetch) else $error("fetch not single cycle");
  property p_acc;
    @(posedge clock_i) disable iff (!rst_n_i)
      (exec_ok && dec_i.op == OP_MOVFF) |=> accumulator_reg == $past(accumulator_reg) || $past(sfr_we_i);
  endproperty
  a_acc: assert property (p_acc) else $error("file move touched accumulator");
  property p_sub_half;
    @(posedge clock_i) disable iff (!rst_n_i)
      (exec_ok && dec_i.op == OP_SUB) |=> arith_status_reg[`F_HALF] == ($past(b_op[3:0]) >= $past(a_op[3:0]));
  endproperty
  a_sub_half: assert property (p_sub_half) else $error("digit borrow wrong");
  property p_sub_ovf;
    @(posedge clock_i) disable iff (!rst_n_i)
      (exec_ok && dec_i.op == OP_SUB) |=> arith_status_reg[`F_OVF] ==
        ($signed({$past(b_op[7]), $past(b_op)}) - $signed({$past(a_op[7]), $past(a_op)}) > 127 ||
         $signed({$past(b_op[7]), $past(b_op)}) - $signed({$past(a_op[7]), $past(a_op)}) < -128);
  endproperty
  a_sub_ovf: assert property (p_sub_ovf) else $error("subtract overflow wrong");
  property p_logic_keep;
    @(posedge clock_i) disable iff (!rst_n_i)
      (exec_ok && logic_op) |=> arith_status_reg[`F_CARRY] == $past(arith_status_reg[`F_CARRY]) &&
        arith_status_reg[`F_OVF] == $past(arith_status_reg[`F_OVF]);
  endproperty
  a_logic_keep: assert property (p_logic_keep) else $error("logic op touched carry or overflow");
  property p_and_zero;
    @(posedge clock_i) disable iff (!rst_n_i)
      (exec_ok && dec_i.op == OP_AND) |=> arith_status_reg[`F_ZERO] == (($past(a_op) & $past(b_op)) == 8'h00);
  endproperty
  a_and_zero: assert property (p_and_zero) else $error("logic zero flag wrong");
  property p_rlc;
    @(posedge clock_i) disable iff (!rst_n_i)
      (exec_ok && dec_i.op == OP_RLC && dec_i.to_acc) |=>
        accumulator_reg == {$past(b_op[6:0]), $past(arith_status_reg[`F_CARRY])} &&
        arith_status_reg[`F_CARRY] == $past(b_op[7]);
  endproperty
  a_rlc: assert property (p_rlc) else $error("rotate wrong");
  property p_table;
    @(posedge clock_i) disable iff (!rst_n_i)
      (exec_ok && dec_i.op == OP_TABLE && !sfr_we_i) |=>
        stall_o && insn_r == `RST_INSN && pc_r == $past(pc_r);
  endproperty
  a_table: assert property (p_table) else $error("table move not two cycles");
  property p_pc_low;
    @(posedge clock_i) disable iff (!rst_n_i)
      (sfr_we_i && sfr_addr_i == `A_PCL_ADDR) |=> pc_r[7:0] == $past(sfr_wdata_i) && stall_o;
  endproperty
  a_pc_low: assert property (p_pc_low) else $error("mapped pc write wrong");
  property p_file_move;
    @(posedge clock_i) disable iff (!rst_n_i)
      (exec_ok && dec_i.op == OP_MOVFF && !dec_i.to_acc) |=>
        dbus_r.we && dbus_r.addr == $past(dec_i.dst) && dbus_r.wdata == $past(b_op);
  endproperty
  a_file_move: assert property (p_file_move) else $error("file to file move wrong");
  property p_acc_read;
    @(posedge clock_i) disable iff (!rst_n_i)
      (sfr_re_i && sfr_addr_i == `A_ACC_ADDR) |=> sfr_rdata_r == $past(accumulator_reg);
  endproperty
  a_acc_read: assert property (p_acc_read) else $error("mapped accumulator read wrong");
  property p_stall_ignore;
    @(posedge clock_i) disable iff (!rst_n_i)
      (!exec_ok && !sfr_we_i) |=>
        accumulator_reg == $past(accumulator_reg) && prod_r == $past(prod_r) && !dbus_r.we;
  endproperty
  a_stall_ignore: assert property (p_stall_ignore) else $error("op executed in flush cycle");
  c_table:   cover property (@(posedge clock_i) exec_ok && dec_i.op == OP_TABLE);
  c_add_ovf: cover property (@(posedge clock_i) exec_ok && dec_i.op == OP_ADD ##1 arith_status_reg[`F_OVF]);
  c_sub:     cover property (@(posedge clock_i) exec_ok && dec_i.op == OP_SUB);
  c_mul:     cover property (@(posedge clock_i) exec_ok && dec_i.op == OP_MUL);
  c_branch:  cover property (@(posedge clock_i) stall_o);
endmodule
`default_nettype wire

// ### alu_core_map.svh
// constants for the arithmetic core: data-map offsets, flag positions, reset values
// assumes the includer compiles the package alu_core_pkg alongside
`ifndef ALU_CORE_MAP_SVH
`define ALU_CORE_MAP_SVH
`define A_PCL_ADDR    8'h02
`define A_STATUS_ADDR 8'h04
`define A_PCH_ADDR    8'h03
`define A_ACC_ADDR    8'h0a
`define A_PRODL_ADDR  8'h18
`define A_PRODH_ADDR  8'h19
`define F_CARRY       0
`define F_HALF        1
`define F_ZERO        2
`define F_OVF         3
`define RST_BYTE      8'h00
`define RST_PC        16'h0000
`define RST_INSN      16'h0000
`endif

// ### alu_core_pkg.sv
// types for the arithmetic core
// assumes nothing of its surroundings
package alu_core_pkg;
  typedef enum logic [3:0] {
    OP_NOP, OP_ADD, OP_ADDC, OP_SUB, OP_SUBB, OP_AND, OP_IOR, OP_XOR,
    OP_RLC, OP_RRC, OP_MUL, OP_MOVWF, OP_MOVFF, OP_BRANCH, OP_TABLE
  } alu_op_t;
  typedef struct packed {
    alu_op_t    op;
    logic [7:0] src;
    logic [7:0] dst;
    logic       to_acc;
  } decode_t;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       we;
  } dbus_t;
  typedef enum logic {ST_RUN, ST_FLUSH} pipe_state_t;
endpackage

// ### tb.sv
// self-checking bench for the arithmetic core: table of unit ops, then hand tests
// assumes alu_core_pkg is compiled first; drives decoder, data memory and map port itself
`timescale 1ns/1ps
`default_nettype none
`include "alu_core_map.svh"
module tb;
  import alu_core_pkg::*;
  logic        clock_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic [15:0] insn_i = 16'h0000;
  decode_t     dec_i = '0;
  logic [7:0]  file_rdata_i = 8'h00;
  logic [7:0]  sfr_addr_i = 8'h00;
  logic        sfr_we_i = 1'b0;
  logic [7:0]  sfr_wdata_i = 8'h00;
  logic        sfr_re_i = 1'b0;
  logic [15:0] pc_o, exec_insn_o, product_o;
  logic [7:0]  file_raddr_o, accumulator_o, arith_status_reg_o, sfr_rdata_o;
  dbus_t       dbus_o;
  logic        stall_o;
  int          error_cnt = 0;
  int          total_checks = 0;
  int          cyc = 0;
  typedef struct packed {alu_op_t op; logic [7:0] st, acc, fil, ea, es;} row_t;
  // status preset, accumulator preset, file value -> expected accumulator and status
  localparam row_t rows [12] = '{
    '{OP_ADD,  8'h00, 8'hff, 8'h01, 8'h00, 8'h07}, '{OP_ADD,  8'h00, 8'h7f, 8'h01, 8'h80, 8'h0a},
    '{OP_SUB,  8'h00, 8'h03, 8'h05, 8'h02, 8'h03}, '{OP_SUB,  8'h00, 8'h05, 8'h03, 8'hfe, 8'h00},
    '{OP_SUB,  8'h00, 8'h01, 8'h80, 8'h7f, 8'h09}, '{OP_ADDC, 8'h01, 8'h0f, 8'h00, 8'h10, 8'h02},
    '{OP_AND,  8'h0b, 8'hf0, 8'h0f, 8'h00, 8'h0f}, '{OP_IOR,  8'h04, 8'ha5, 8'h5a, 8'hff, 8'h00},
    '{OP_XOR,  8'h00, 8'h3c, 8'h3c, 8'h00, 8'h04}, '{OP_RLC,  8'h00, 8'h00, 8'h81, 8'h02, 8'h01},
    '{OP_RRC,  8'h01, 8'h00, 8'h01, 8'h80, 8'h01}, '{OP_SUBB, 8'h00, 8'h01, 8'h05, 8'h03, 8'h03}};
  alu_status_multiplier_core alu_status_multiplier_core_i (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .insn_i(insn_i), .dec_i(dec_i), .file_rdata_i(file_rdata_i),
    .sfr_addr_i(sfr_addr_i), .sfr_we_i(sfr_we_i), .sfr_wdata_i(sfr_wdata_i), .sfr_re_i(sfr_re_i),
    .pc_o(pc_o), .exec_insn_o(exec_insn_o), .file_raddr_o(file_raddr_o), .dbus_o(dbus_o),
    .accumulator_o(accumulator_o), .arith_status_reg_o(arith_status_reg_o), .product_o(product_o),
    .sfr_rdata_o(sfr_rdata_o), .stall_o(stall_o));
  always #25 clock_i = ~clock_i;
  ////////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // hang guard: the whole run needs well under 2000 cycles
  always @(posedge clock_i) begin
    cyc++;
    if (cyc == 2000) begin
      error_cnt++;
      give_verdict();
    end
  end
  task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock_i);
    sfr_addr_i <= a; sfr_wdata_i <= d; sfr_we_i <= 1'b1;
    @(posedge clock_i);
    sfr_we_i <= 1'b0;
  endtask
  // read data stand from the cycle after the strobe until the next read
  task automatic sfr_rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock_i);
    sfr_addr_i <= a; sfr_re_i <= 1'b1;
    @(posedge clock_i);
    sfr_re_i <= 1'b0;
    #1 d = sfr_rdata_o;
  endtask
  // op is taken at the edge after it is set; results checked just after that edge
  task automatic do_op(input alu_op_t op, input logic [7:0] s, input logic [7:0] d, input logic ta,
                       input logic [7:0] f);
    @(posedge clock_i);
    dec_i <= '{op: op, src: s, dst: d, to_acc: ta}; file_rdata_i <= f;
    @(posedge clock_i);
    dec_i <= '0;
    #1;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [7:0] rd;
    logic [7:0] lo;
    repeat (5) @(posedge clock_i);
    #1 chk({accumulator_o, arith_status_reg_o}, 16'h0000);
    chk(pc_o | product_o | {15'h0000, stall_o}, 16'h0000);
    rst_n_i <= 1'b1;
    $display("test reset done");
    foreach (rows[i]) begin
      sfr_wr(`A_ACC_ADDR, rows[i].acc);
      sfr_wr(`A_STATUS_ADDR, rows[i].st);
      do_op(rows[i].op, 8'h20, 8'h30, 1'b1, rows[i].fil);
      chk({8'h00, accumulator_o}, {8'h00, rows[i].ea});
      chk({8'h00, arith_status_reg_o}, {8'h00, rows[i].es});
    end
    $display("test table done");
    sfr_wr(`A_ACC_ADDR, 8'hff);
    do_op(OP_MUL, 8'h21, 8'h31, 1'b0, 8'hfe);
    chk(product_o, 16'hfd02);
    sfr_rd(`A_PRODL_ADDR, lo);
    sfr_rd(`A_PRODH_ADDR, rd);
    chk({rd, lo}, 16'hfd02);
    sfr_rd(`A_ACC_ADDR, rd);
    chk({8'h00, rd}, 16'h00ff);
    $display("test multiply done");
    @(posedge clock_i);
    dec_i <= '{op: OP_MOVFF, src: 8'h41, dst: 8'h52, to_acc: 1'b0}; file_rdata_i <= 8'h6d;
    #1 chk({8'h00, file_raddr_o}, 16'h0041);
    @(posedge clock_i);
    dec_i <= '0;
    #1 chk({dbus_o.addr, dbus_o.wdata}, 16'h526d);
    chk({7'h00, dbus_o.we, accumulator_o}, 16'h01ff);
    @(posedge clock_i);
    #1 chk({15'h0000, dbus_o.we}, 16'h0000);
    $display("test file move done");
    @(posedge clock_i);
    insn_i <= 16'hbeef;
    @(posedge clock_i);
    #1 chk(exec_insn_o, 16'hbeef);
    lo = pc_o[7:0];
    @(posedge clock_i);
    #1 chk({8'h00, pc_o[7:0]}, {8'h00, lo + 8'h01});
    @(posedge clock_i);
    dec_i <= '{op: OP_BRANCH, src: 8'hfe, dst: 8'hff, to_acc: 1'b0}; file_rdata_i <= 8'h00;
    @(posedge clock_i);
    dec_i <= '{op: OP_ADD, src: 8'h20, dst: 8'h30, to_acc: 1'b1}; file_rdata_i <= 8'h01;
    #1 chk(pc_o, 16'hfffe);
    chk({15'h0000, stall_o}, 16'h0001);
    @(posedge clock_i);
    dec_i <= '0;
    #1 chk({15'h0000, stall_o, accumulator_o}, 16'h00ff);
    $display("test branch done");
    // two-byte add: the low byte's overflow is dropped, only the high byte's counts
    sfr_wr(`A_STATUS_ADDR, 8'h00);
    sfr_wr(`A_ACC_ADDR, 8'h80);
    do_op(OP_ADD, 8'h20, 8'h30, 1'b1, 8'h80);
    chk({accumulator_o, arith_status_reg_o}, 16'h000d);
    sfr_wr(`A_ACC_ADDR, 8'h01);
    do_op(OP_ADDC, 8'h21, 8'h31, 1'b1, 8'h00);
    chk({accumulator_o, arith_status_reg_o}, 16'h0200);
    $display("test wide add done");
    do_op(OP_MOVWF, 8'h22, 8'h33, 1'b0, 8'h00);
    chk({dbus_o.addr, dbus_o.wdata}, 16'h3302);
    chk({7'h00, dbus_o.we, accumulator_o}, 16'h0102);
    do_op(OP_TABLE, 8'h00, 8'h00, 1'b0, 8'h00);
    chk(exec_insn_o, 16'h0000);
    chk({15'h0000, stall_o}, 16'h0001);
    $display("test table move done");
    sfr_wr(`A_PCL_ADDR, 8'h34);
    #1 chk({pc_o[7:0], 7'h00, stall_o}, 16'h3401);
    sfr_wr(`A_PCH_ADDR, 8'h12);
    #1 chk(pc_o, 16'h1235);
    sfr_wr(`A_STATUS_ADDR, 8'hfb);
    sfr_rd(`A_STATUS_ADDR, rd);
    chk({8'h00, rd}, 16'h000b);
    $display("test mapped registers done");
    @(posedge clock_i);
    rst_n_i <= 1'b0;
    #1 chk({accumulator_o, arith_status_reg_o}, 16'h0000);
    chk(pc_o | product_o, 16'h0000);
    $display("test second reset done");
    give_verdict();
  end
endmodule
`default_nettype wire
